// *** dv/ccm_props.sv ***
// Port-level properties of the colour conversion matrix block
`timescale 1ns/10ps
module ccm_props
   import ccm_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        reset_n,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        pix_valid,
   input wire logic        pix_sol,
   input wire logic        pix_eol,
   input wire logic        out_valid,
   input wire logic        out_sol,
   input wire logic        out_eol
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);

   property p_lat; pix_valid |-> ##3 out_valid; endproperty
   a_lat: assert property (p_lat) else $error("pixel lost");
   property p_src; out_valid |-> $past(pix_valid, 3); endproperty
   a_src: assert property (p_src) else $error("stray pixel");
   property p_sol; pix_valid && pix_sol |-> ##3 out_sol; endproperty
   a_sol: assert property (p_sol) else $error("line start lost");
   property p_eol;
      out_eol |-> $past(pix_eol, 3) && $past(pix_valid, 3);
   endproperty
   a_eol: assert property (p_eol) else $error("stray line end");
   property p_eolf; pix_valid && pix_eol |-> ##3 out_eol; endproperty
   a_eolf: assert property (p_eolf) else $error("line end lost");
   property p_mark; out_sol || out_eol |-> out_valid; endproperty
   a_mark: assert property (p_mark) else $error("marker alone");
   property p_fix;
      reg_rd && reg_addr == 8'h00 |=> reg_rdata == {19'h0, CCM_SRGB[0]};
   endproperty
   a_fix: assert property (p_fix) else $error("fixed set moved");
   property p_wrrd;
      reg_wr && reg_addr == 8'h44 && reg_wdata == 32'h123
      ##[1:2] reg_rd && reg_addr == 8'h44 |=> reg_rdata == 32'h123;
   endproperty
   a_wrrd: assert property (p_wrrd) else $error("write lost");
   property p_skew;
      reg_rd && reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0;
   endproperty
   a_skew: assert property (p_skew) else $error("misaligned read");
endmodule

bind ccm_top ccm_props ccm_props_i (.core_clk, .reset_n, .reg_addr,
   .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pix_valid, .pix_sol,
   .pix_eol, .out_valid, .out_sol, .out_eol);

// *** dv/ccm_src.sv ***
// Upstream pixel pipeline model feeding lines into the block
`timescale 1ns/10ps
module ccm_src (
   input  wire logic  core_clk,
   output logic       pix_valid,
   output logic       pix_sol,
   output logic       pix_eol,
   output logic [9:0] pix_red,
   output logic [9:0] pix_green,
   output logic [9:0] pix_blue
);
   initial begin
      pix_valid = 1'b0;
      pix_sol = 1'b0;
      pix_eol = 1'b0;
      pix_red = 10'h0;
      pix_green = 10'h0;
      pix_blue = 10'h0;
   end

   // Idle cycles drop pix_valid and invert every other output so stale values are never reused
   task automatic idle;
      pix_valid <= 1'b0;
      pix_sol   <= ~pix_sol;
      pix_eol   <= ~pix_eol;
      pix_red   <= ~pix_red;
      pix_green <= ~pix_green;
      pix_blue  <= ~pix_blue;
   endtask

   task automatic send_line(input int n, input int gap, input bit ext);
      logic [31:0] v;
      for (int i = 0; i < n; i++) begin
         @(posedge core_clk);
         v = $urandom;
         pix_valid <= 1'b1;
         pix_sol   <= (i == 0);
         pix_eol   <= (i == n - 1);
         pix_red   <= ext ? {10{v[0]}} : v[9:0];
         pix_green <= ext ? {10{v[1]}} : v[19:10];
         pix_blue  <= ext ? {10{v[2]}} : v[29:20];
         repeat (gap) begin
            @(posedge core_clk);
            idle();
         end
      end
      @(posedge core_clk);
      idle();
   endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the colour conversion matrix block
`timescale 1ns/10ps
module testbench;
   import ccm_pkg::*;
   logic        core_clk, reset_n, reg_wr, reg_rd;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic        pix_valid, pix_sol, pix_eol, out_valid, out_sol, out_eol;
   logic [9:0]  pix_red, pix_green, pix_blue, out_red, out_green, out_blue;
   int          fails, n_tests, sel, gam, asel, agam, cf[4][9], of[4][3];
   int          q[$];
   int          gv[4] = '{10, 1, 2, 5};
   logic [29:0] got;

   ccm_top ccm_top_i (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .pix_valid, .pix_sol, .pix_eol, .pix_red,
      .pix_green, .pix_blue, .out_valid, .out_sol, .out_eol, .out_red,
      .out_green, .out_blue);
   ccm_src ccm_src_i (.core_clk, .pix_valid, .pix_sol, .pix_eol, .pix_red,
      .pix_green, .pix_blue);

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask

   function automatic int crv(int x);
      int s;
      s = x >> 7;
      if (agam == 1)
         return CCM_KNOT_SRGB[s] + (((CCM_KNOT_SRGB[s + 1]
            - CCM_KNOT_SRGB[s]) * (x & 127)) >>> 7);
      if (agam == 2)
         return CCM_KNOT_MSPEC[s] + (((CCM_KNOT_MSPEC[s + 1]
            - CCM_KNOT_MSPEC[s]) * (x & 127)) >>> 7);
      return x;
   endfunction

   function automatic int px(int k);
      int a;
      int p[3];
      p = '{pix_red, pix_green, pix_blue};
      a = 0;
      for (int j = 0; j < 3; j++)
         a += cf[asel][k * 3 + j] * (p[j] + of[asel][j]);
      a = a >>> 10;
      return crv(a < 0 ? 0 : a > 1023 ? 1023 : a);
   endfunction

   function automatic logic [31:0] rexp(logic [7:0] a);
      int c;
      c = (agam == 1) ? 1 : (agam == 2) ? 2 : 0;
      if (a == CCM_ADDR_CTRL) return {16'h0, gam[7:0], 6'h0, sel[1:0]};
      if (a == CCM_ADDR_STAT) return {22'h0, c[1:0], 6'h0, asel[1:0]};
      if (a[1:0] != 2'h0 || a[5:2] > 4'hb) return 32'h0;
      if (a[5:2] < 4'h9) return cf[a[7:6]][a[5:2]] & 32'h1fff;
      return of[a[7:6]][a[5:2] - 9] & 32'h3ff;
   endfunction

   task automatic wmodel(logic [7:0] a, logic [31:0] d);
      int v;
      int m;
      v = d;
      if (a == CCM_ADDR_CTRL) begin
         sel = d[1:0];
         gam = d[15:8];
      end
      if (a[7:6] == 2'h0 || a[1:0] != 2'h0 || a[5:2] > 4'hb) return;
      m = a[5:2] < 4'h9 ? CCM_COEF_LIM : CCM_OFF_LIM;
      v = v > m ? m : v < -m ? -m : v;
      if (a[5:2] < 4'h9) cf[a[7:6]][a[5:2]] = v;
      else of[a[7:6]][a[5:2] - 9] = v;
   endtask

   always @(posedge core_clk) begin
      if (out_valid === 1'b1) begin
         if (q.size() == 0) chk("stray pixel", 0, 1);
         else begin
            got = {out_red, out_green, out_blue};
            chk("pixel", q.pop_front(), {2'h0, got});
         end
      end
      if (pix_valid === 1'b1) begin
         if (pix_sol === 1'b1) begin
            asel = sel;
            agam = gam;
         end
         q.push_back((px(0) << 20) | (px(1) << 10) | px(2));
      end
      if (reg_wr === 1'b1) wmodel(reg_addr, reg_wdata);
   end

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(logic [7:0] a);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("register", rexp(a), reg_rdata);
   endtask

   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      conclude();
   end

   initial begin
      void'($urandom(32'h159f));
      fails = 0;
      n_tests = 0;
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      sel = 0;
      gam = 10;
      asel = 0;
      agam = 0;
      for (int s = 0; s < 4; s++) begin
         for (int i = 0; i < 9; i++)
            cf[s][i] = s == 0 ? CCM_SRGB[i] : (i % 4 == 0) ? 1024 : 0;
         of[s] = '{0, 0, 0};
      end
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      for (int a = 0; a < 256; a += 4) rd(a);
      rd(8'h41);
      for (int a = 0; a < 256; a += 4)
         wr(a, $urandom_range(6000) - 3000);
      for (int a = 0; a < 256; a += 4) rd(a);
      wr(8'h44, 32'h123);
      rd(8'h44);
      for (int k = 0; k < 16; k++) begin
         wr(CCM_ADDR_CTRL, (gv[k % 4] << 8) | (k / 4));
         fork
            ccm_src_i.send_line(12, k % 3, k[0]);
            begin
               repeat (5) @(posedge core_clk);
               wr(CCM_ADDR_CTRL, 32'h0203);
            end
         join
         repeat (6) @(posedge core_clk);
         rd(CCM_ADDR_STAT);
      end
      chk("pending pixels", 0, q.size());
      conclude();
   end
endmodule

// *** include/ccm_pkg.sv ***
// Constants and types shared by the colour conversion matrix block
package ccm_pkg;

   // ======================================================================
   // Datapath widths and counts
   localparam int CCM_PIX_W  = 10;
   localparam int CCM_COEF_W = 13;
   localparam int CCM_FRAC_W = 10;
   localparam int CCM_OFF_W  = 10;
   localparam int CCM_SUM_W  = 12;
   localparam int CCM_PROD_W = 25;
   localparam int CCM_ACC_W  = 27;
   localparam int CCM_SETS   = 4;
   localparam int CCM_TAPS   = 9;
   localparam int CCM_CH     = 3;
   localparam int CCM_KNOTS  = 9;
   localparam int CCM_SEG_W  = 7;

   // ======================================================================
   // Value limits, gain 1.0 is 2**CCM_FRAC_W
   localparam int                   CCM_COEF_LIM = 2048;
   localparam int                   CCM_OFF_LIM  = 511;
   localparam logic signed [12:0]   CCM_COEF_MAX = 13'sh0800;
   localparam logic signed [12:0]   CCM_COEF_MIN = 13'sh1800;
   localparam logic signed [12:0]   CCM_UNITY    = 13'sh0400;
   localparam logic signed [9:0]    CCM_OFF_MAX  = 10'sh1ff;
   localparam logic signed [9:0]    CCM_OFF_MIN  = 10'sh201;
   localparam logic [9:0]           CCM_PIX_MAX  = 10'h3ff;

   // ======================================================================
   // Register map, byte addresses; set s item i at s*0x40 + i*4
   localparam int         CCM_ADDR_W    = 8;
   localparam logic [7:0] CCM_ADDR_CTRL = 8'h30;
   localparam logic [7:0] CCM_ADDR_STAT = 8'h34;
   localparam logic [3:0] CCM_ITEM_OFF0 = 4'h9;
   localparam logic [3:0] CCM_ITEMS     = 4'hc;
   localparam int         CCM_SEL_LSB   = 0;
   localparam int         CCM_GAMMA_LSB = 8;
   localparam int         CCM_STAT_CURVE_LSB = 8;
   localparam logic [1:0] CCM_SEL_RST   = 2'h0;
   // Gamma setting in tenths: 1 means 0.1, 10 means 1.0
   localparam logic [7:0] CCM_GAMMA_RST   = 8'h0a;
   localparam logic [7:0] CCM_GAMMA_SRGB  = 8'h01;
   localparam logic [7:0] CCM_GAMMA_MSPEC = 8'h02;

   typedef enum logic [1:0] {
      CCM_CURVE_LIN,
      CCM_CURVE_SRGB,
      CCM_CURVE_MSPEC
   } ccm_curve_t;

   // ======================================================================
   // Fixed conversion of set one, rows sum to unity
   localparam logic signed [12:0] CCM_SRGB [CCM_TAPS] = '{
      13'sh05a0, 13'sh1ee0, 13'sh1f80,
      13'sh1f40, 13'sh0580, 13'sh1f40,
      13'sh1fc0, 13'sh1ec0, 13'sh0580};

   // Transfer curve knots at every eighth of full scale
   localparam logic [9:0] CCM_KNOT_SRGB [CCM_KNOTS] = '{
      10'h000, 10'h18e, 10'h225, 10'h294, 10'h2f0,
      10'h340, 10'h385, 10'h3c5, 10'h3ff};
   localparam logic [9:0] CCM_KNOT_MSPEC [CCM_KNOTS] = '{
      10'h000, 10'h0d0, 10'h168, 10'h1e8, 10'h250,
      10'h2b0, 10'h310, 10'h360, 10'h3ff};

endpackage

// *** verilog/ccm_curve.sv ***
// Per-channel transfer curve stage with piecewise-linear tables
`timescale 1ns/10ps
module ccm_curve
   import ccm_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire ccm_curve_t curve,
   input  wire logic [9:0] pix_in,
   output logic [9:0]      pix_out
);

   logic [9:0] pix_r;
   logic [9:0] pix_nxt;
   logic [3:0] seg;
   logic [6:0] frac;

   // ======================================================================
   // Interpolation between two knots
   function automatic logic [9:0] ccm_interp(input logic [9:0] lo,
                                             input logic [9:0] hi,
                                             input logic [6:0] f);
      logic signed [11:0] d;
      logic signed [19:0] p;
      logic signed [11:0] t;
      d = $signed({2'b00, hi}) - $signed({2'b00, lo});
      p = 20'(d * $signed({1'b0, f}));
      t = $signed({2'b00, lo}) + 12'(p >>> CCM_SEG_W);
      ccm_interp = t[9:0];
   endfunction

   // ======================================================================
   // Table selection
   always_comb begin
      seg  = {1'b0, pix_in[9:7]};
      frac = pix_in[6:0];
      case (curve)
         CCM_CURVE_SRGB: begin
            pix_nxt = ccm_interp(CCM_KNOT_SRGB[seg],
                                 CCM_KNOT_SRGB[4'(seg + 4'h1)], frac);
         end
         CCM_CURVE_MSPEC: begin
            pix_nxt = ccm_interp(CCM_KNOT_MSPEC[seg],
                                 CCM_KNOT_MSPEC[4'(seg + 4'h1)], frac);
         end
         default: begin
            pix_nxt = pix_in;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pix_r <= 10'h000;
      end else begin
         pix_r <= pix_nxt;
      end
   end

   assign pix_out = pix_r;

endmodule

// *** verilog/ccm_top.sv ***
// Colour conversion matrix datapath with register port
//
// Contract
// - Four independent coefficient sets, any applicable
// - Offsets signed, clamped to -511..+511
// - Gains signed fixed point, clamped to +-2
// - Set one fixed conversion, writes rejected
// - Sets two to four reset to identity
// - Sets two to four accept new values
// - Gamma 0.1 selects the sRGB table
// - Gamma 0.2 selects the multi-spectral table
`timescale 1ns/10ps
module ccm_top
   import ccm_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic [31:0]      reg_rdata,
   input  wire logic        pix_valid,
   input  wire logic        pix_sol,
   input  wire logic        pix_eol,
   input  wire logic [9:0]  pix_red,
   input  wire logic [9:0]  pix_green,
   input  wire logic [9:0]  pix_blue,
   output logic             out_valid,
   output logic             out_sol,
   output logic             out_eol,
   output logic [9:0]       out_red,
   output logic [9:0]       out_green,
   output logic [9:0]       out_blue
);

   logic [1:0]               rst_sync_r;
   logic                     rst_n;
   logic signed [12:0]       coef_r   [CCM_SETS][CCM_TAPS];
   logic signed [12:0]       coef_nxt [CCM_SETS][CCM_TAPS];
   logic signed [9:0]        off_r    [CCM_SETS][CCM_CH];
   logic signed [9:0]        off_nxt  [CCM_SETS][CCM_CH];
   logic [1:0]               sel_r;
   logic [1:0]               sel_nxt;
   logic [7:0]               gamma_r;
   logic [7:0]               gamma_nxt;
   logic [31:0]              rdata_r;
   logic [31:0]              rdata_nxt;
   logic [1:0]               wr_set;
   logic [3:0]               wr_item;
   logic [1:0]               act_set_r;
   logic [1:0]               act_set_nxt;
   ccm_curve_t               act_curve_r;
   ccm_curve_t               act_curve_nxt;
   logic [9:0]               pix_in   [CCM_CH];
   logic [2:0]               s1_flag_r;
   logic [2:0]               s2_flag_r;
   logic [2:0]               s3_flag_r;
   logic [1:0]               s1_set_r;
   ccm_curve_t               s1_curve_r;
   ccm_curve_t               s2_curve_r;
   logic signed [11:0]       s1_sum_r   [CCM_CH];
   logic signed [11:0]       s1_sum_nxt [CCM_CH];
   logic [9:0]               s2_lin_r   [CCM_CH];
   logic [9:0]               s2_lin_nxt [CCM_CH];
   logic signed [24:0]       prod;
   logic signed [26:0]       acc;
   logic [9:0]               curve_out  [CCM_CH];

   // ======================================================================
   // Reset release
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ======================================================================
   // Helpers
   function automatic logic signed [12:0] clamp_coef(input logic [31:0] w);
      if ($signed(w) > CCM_COEF_LIM) begin
         clamp_coef = CCM_COEF_MAX;
      end else if ($signed(w) < -CCM_COEF_LIM) begin
         clamp_coef = CCM_COEF_MIN;
      end else begin
         clamp_coef = w[12:0];
      end
   endfunction

   function automatic logic signed [9:0] clamp_off(input logic [31:0] w);
      if ($signed(w) > CCM_OFF_LIM) begin
         clamp_off = CCM_OFF_MAX;
      end else if ($signed(w) < -CCM_OFF_LIM) begin
         clamp_off = CCM_OFF_MIN;
      end else begin
         clamp_off = w[9:0];
      end
   endfunction

   function automatic ccm_curve_t curve_of(input logic [7:0] g);
      if (g == CCM_GAMMA_SRGB) begin
         curve_of = CCM_CURVE_SRGB;
      end else if (g == CCM_GAMMA_MSPEC) begin
         curve_of = CCM_CURVE_MSPEC;
      end else begin
         curve_of = CCM_CURVE_LIN;
      end
   endfunction

   // ======================================================================
   // Register port
   assign wr_set  = reg_addr[7:6];
   assign wr_item = reg_addr[5:2];

   always_comb begin
      coef_nxt  = coef_r;
      off_nxt   = off_r;
      sel_nxt   = sel_r;
      gamma_nxt = gamma_r;
      rdata_nxt = 32'h0000_0000;
      if (reg_wr) begin
         if (reg_addr == CCM_ADDR_CTRL) begin
            sel_nxt   = reg_wdata[CCM_SEL_LSB +: 2];
            gamma_nxt = reg_wdata[CCM_GAMMA_LSB +: 8];
         end else if (reg_addr[1:0] != 2'h0 || wr_set == 2'h0) begin
            // Set one stays fixed
            coef_nxt = coef_r;
         end else if (wr_item < CCM_ITEM_OFF0) begin
            coef_nxt[wr_set][wr_item] = clamp_coef(reg_wdata);
         end else if (wr_item < CCM_ITEMS) begin
            off_nxt[wr_set][2'(wr_item - CCM_ITEM_OFF0)] =
               clamp_off(reg_wdata);
         end
      end
      if (reg_rd) begin
         if (reg_addr == CCM_ADDR_CTRL) begin
            rdata_nxt[CCM_SEL_LSB +: 2]   = sel_r;
            rdata_nxt[CCM_GAMMA_LSB +: 8] = gamma_r;
         end else if (reg_addr == CCM_ADDR_STAT) begin
            rdata_nxt[CCM_SEL_LSB +: 2]        = act_set_r;
            rdata_nxt[CCM_STAT_CURVE_LSB +: 2] = act_curve_r;
         end else if (reg_addr[1:0] != 2'h0) begin
            rdata_nxt = 32'h0000_0000;
         end else if (wr_item < CCM_ITEM_OFF0) begin
            rdata_nxt[12:0] = coef_r[wr_set][wr_item];
         end else if (wr_item < CCM_ITEMS) begin
            rdata_nxt[9:0] = off_r[wr_set][2'(wr_item - CCM_ITEM_OFF0)];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int s = 0; s < CCM_SETS; s++) begin
            for (int k = 0; k < CCM_TAPS; k++) begin
               if (s == 0) begin
                  coef_r[s][k] <= CCM_SRGB[k];
               end else if (k % 4 == 0) begin
                  coef_r[s][k] <= CCM_UNITY;
               end else begin
                  coef_r[s][k] <= 13'sh0000;
               end
            end
            for (int c = 0; c < CCM_CH; c++) begin
               off_r[s][c] <= 10'sh000;
            end
         end
         sel_r   <= CCM_SEL_RST;
         gamma_r <= CCM_GAMMA_RST;
         rdata_r <= 32'h0000_0000;
      end else begin
         coef_r  <= coef_nxt;
         off_r   <= off_nxt;
         sel_r   <= sel_nxt;
         gamma_r <= gamma_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;

   // ======================================================================
   // Line-boundary selection and offset stage
   assign pix_in[0] = pix_red;
   assign pix_in[1] = pix_green;
   assign pix_in[2] = pix_blue;

   always_comb begin
      act_set_nxt   = act_set_r;
      act_curve_nxt = act_curve_r;
      if (pix_valid && pix_sol) begin
         act_set_nxt   = sel_r;
         act_curve_nxt = curve_of(gamma_r);
      end
      for (int c = 0; c < CCM_CH; c++) begin
         s1_sum_nxt[c] = $signed({2'b00, pix_in[c]}) +
                         12'(off_r[act_set_nxt][c]);
      end
   end

   // ======================================================================
   // Matrix stage
   always_comb begin
      prod = 25'sh0000000;
      acc  = 27'sh0000000;
      for (int r = 0; r < CCM_CH; r++) begin
         acc = 27'sh0000000;
         for (int k = 0; k < CCM_CH; k++) begin
            prod = 25'(coef_r[s1_set_r][r * 3 + k] * s1_sum_r[k]);
            acc  = 27'(acc + 27'(prod));
         end
         if (acc < 0) begin
            s2_lin_nxt[r] = 10'h000;
         end else if (acc[26:20] != 7'h00) begin
            s2_lin_nxt[r] = CCM_PIX_MAX;
         end else begin
            s2_lin_nxt[r] = acc[19:10];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         act_set_r   <= 2'h0;
         act_curve_r <= CCM_CURVE_LIN;
         s1_set_r    <= 2'h0;
         s1_curve_r  <= CCM_CURVE_LIN;
         s2_curve_r  <= CCM_CURVE_LIN;
         s1_flag_r   <= 3'h0;
         s2_flag_r   <= 3'h0;
         s3_flag_r   <= 3'h0;
         for (int c = 0; c < CCM_CH; c++) begin
            s1_sum_r[c] <= 12'sh000;
            s2_lin_r[c] <= 10'h000;
         end
      end else begin
         act_set_r   <= act_set_nxt;
         act_curve_r <= act_curve_nxt;
         s1_set_r    <= act_set_nxt;
         s1_curve_r  <= act_curve_nxt;
         s2_curve_r  <= s1_curve_r;
         s1_flag_r   <= {pix_valid, pix_sol & pix_valid, pix_eol & pix_valid};
         s2_flag_r   <= s1_flag_r;
         s3_flag_r   <= s2_flag_r;
         s1_sum_r    <= s1_sum_nxt;
         s2_lin_r    <= s2_lin_nxt;
      end
   end

   // ======================================================================
   // Transfer curve stage
   for (genvar c = 0; c < CCM_CH; c++) begin : g_curve
      ccm_curve u_curve (
         .core_clk (core_clk),
         .rst_n    (rst_n),
         .curve    (s2_curve_r),
         .pix_in   (s2_lin_r[c]),
         .pix_out  (curve_out[c])
      );
   end

   assign out_valid = s3_flag_r[2];
   assign out_sol   = s3_flag_r[1];
   assign out_eol   = s3_flag_r[0];
   assign out_red   = curve_out[0];
   assign out_green = curve_out[1];
   assign out_blue  = curve_out[2];

endmodule
